/* core/bsc_pkg.sv */
// shared constants, types and register map for the buck switch controller
package bsc_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int BLANK_NS = 12000;
  // least time, so round up to whole cycles
  localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOFF_CYC = 896;
  localparam int HTRY_CYC = 112;
  localparam int PG_CYC = 48;
  localparam int HCNT_W = 10;
  localparam int PGCNT_W = 6;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] PERIOD_RST = 8'h19;
  localparam logic [7:0] PERIOD_MIN = 8'h04;
  localparam int ST_POS = 8;
  localparam int PG_POS = 12;
  localparam int ILIM_POS = 13;
  localparam int RATIO_POS = 0;

  // ----------------------------------------------------------------------
  // strap levels and the preset ratio index
  // ----------------------------------------------------------------------
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_OPEN = 2'h1;
  localparam logic [1:0] LVL_VDD = 2'h2;
  typedef logic [3:0] bsc_ratio_t;

  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_RUN = 4'b0010,
    ST_HOFF = 4'b0100,
    ST_HTRY = 4'b1000
  } bsc_state_e;

  // comparator and pin flags from the analog side, all asynchronous
  typedef struct packed {
    logic enable;
    logic ramp_trip;
    logic hs_oc;
    logic ls_oc;
    logic fb_low70;
    logic supply_low;
    logic over_temp;
    logic fb_above_pg;
    logic fb_below_pg;
    logic ref_ok;
    logic [1:0] output_select_a;
    logic [1:0] output_select_b;
  } bsc_flags_s;

endpackage

/* core/bsc_sync.sv */
// three-stage synchroniser, output moves once stages two and three agree
module bsc_sync import bsc_pkg::*; #(
  parameter int W = 1
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // ----------------------------------------------------------------------
  // per-bit stages
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge mclk_i) begin
      if (rst_i) begin
        s1[i] <= 1'b0;
        s2[i] <= 1'b0;
        s3[i] <= 1'b0;
        q_o[i] <= 1'b0;
      end else begin
        s1[i] <= d_i[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i]) begin
          q_o[i] <= s3[i];
        end
      end
    end
  end

  agree_a: assert property (@(posedge mclk_i) disable iff (rst_i)
    (s2 == s3) |=> (q_o == $past(s3)))
    else $error("synchroniser output missed an agreed level");

endmodule

/* core/bsc_ctrl.sv */
// switch control and protection sequencer with apb status and control
module bsc_ctrl import bsc_pkg::*; (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire bsc_flags_s flags_i,
  output logic hs_on_o,
  output logic ls_on_o,
  output logic comp_pulldown_o,
  output logic reference_input_node_pulldown_o,
  output logic ss_enable_o,
  output logic [3:0] sel_ratio_o,
  input wire logic power_good_flag_i,
  output logic power_good_flag_o,
  output logic power_good_flag_oe_o
);

  bsc_flags_s fl;
  bsc_state_e st;
  logic run;
  logic sw;
  logic [7:0] period;
  logic [7:0] pcnt;
  logic wrap;
  logic hs_done;
  logic boot_ok;
  logic ilim_hold;
  logic lim_now;
  logic lim_prev;
  logic limiting;
  logic [HCNT_W-1:0] blank_cnt;
  logic [HCNT_W-1:0] hcnt;
  logic fault_seen;
  logic want_hs;
  logic want_ls;
  logic next_hs;
  logic next_ls;
  logic pg_good;
  logic pg_bad;
  logic [PGCNT_W-1:0] good_cnt;
  logic [PGCNT_W-1:0] bad_cnt;
  logic [3:0] ratio_dec;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------------
  bsc_sync #(.W($bits(bsc_flags_s))) u_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .d_i(flags_i),
    .q_o(fl)
  );

  // disable, lockout and overtemperature all act as the control reset
  assign run = fl.enable & ~fl.supply_low & ~fl.over_temp;
  assign sw = (st == ST_RUN) || (st == ST_HTRY);

  // ----------------------------------------------------------------------
  // operating state
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i || !run) begin
      st <= ST_OFF;
      hcnt <= '0;
    end else begin
      unique case (st)
        ST_OFF: begin
          st <= ST_RUN;
        end
        ST_RUN: begin
          if (limiting && fl.fb_low70 &&
              blank_cnt == HCNT_W'(BLANK_CYC - 1)) begin
            st <= ST_HOFF;
            hcnt <= '0;
          end
        end
        ST_HOFF: begin
          if (hcnt == HCNT_W'(HOFF_CYC - 1)) begin
            st <= ST_HTRY;
            hcnt <= '0;
          end else begin
            hcnt <= hcnt + 1'b1;
          end
        end
        ST_HTRY: begin
          if (hcnt == HCNT_W'(HTRY_CYC - 1)) begin
            st <= (fault_seen || fl.hs_oc) ? ST_HOFF : ST_RUN;
            hcnt <= '0;
          end else begin
            hcnt <= hcnt + 1'b1;
          end
        end
      endcase
    end
  end

  // fault seen at any point of the retry window sends it back off
  always_ff @(posedge mclk_i) begin
    if (rst_i || st != ST_HTRY) begin
      fault_seen <= 1'b0;
    end else if (fl.hs_oc) begin
      fault_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // oscillator cycle
  // ----------------------------------------------------------------------
  assign wrap = (pcnt == period - 8'h01);

  always_ff @(posedge mclk_i) begin
    if (rst_i || !sw || wrap) begin
      pcnt <= '0;
    end else begin
      pcnt <= pcnt + 8'h01;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || !sw || wrap) begin
      hs_done <= 1'b0;
    end else if (fl.ramp_trip || fl.hs_oc) begin
      hs_done <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // current limit and blanking
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i || !sw) begin
      ilim_hold <= 1'b0;
    end else if (fl.hs_oc) begin
      ilim_hold <= 1'b1;
    end else if (!fl.ls_oc) begin
      ilim_hold <= 1'b0;
    end
  end

  // limiting means a peak trip in this cycle or the one before
  always_ff @(posedge mclk_i) begin
    if (rst_i || !sw) begin
      lim_now <= 1'b0;
      lim_prev <= 1'b0;
    end else if (wrap) begin
      lim_prev <= lim_now | fl.hs_oc;
      lim_now <= 1'b0;
    end else if (fl.hs_oc) begin
      lim_now <= 1'b1;
    end
  end
  assign limiting = lim_now | lim_prev | ilim_hold;

  // counts whole clock cycles so the window never comes up short
  always_ff @(posedge mclk_i) begin
    if (rst_i || st != ST_RUN || !limiting || !fl.fb_low70) begin
      blank_cnt <= '0;
    end else if (blank_cnt != HCNT_W'(BLANK_CYC - 1)) begin
      blank_cnt <= blank_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // gate drive requests
  // ----------------------------------------------------------------------
  // high side waits until the low side has charged the bootstrap once
  always_ff @(posedge mclk_i) begin
    if (rst_i || !sw) begin
      boot_ok <= 1'b0;
    end else if (ls_on_o) begin
      boot_ok <= 1'b1;
    end
  end

  always_comb begin
    want_hs = sw & boot_ok & ~hs_done & ~fl.ramp_trip & ~fl.hs_oc &
              ~ilim_hold;
    want_ls = sw & ~want_hs;
    // each side may rise only while the other stands off
    next_hs = want_hs & ~ls_on_o;
    next_ls = want_ls & ~hs_on_o;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      hs_on_o <= 1'b0;
      ls_on_o <= 1'b0;
    end else begin
      hs_on_o <= next_hs;
      ls_on_o <= next_ls;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      comp_pulldown_o <= 1'b0;
      reference_input_node_pulldown_o <= 1'b0;
      ss_enable_o <= 1'b0;
    end else begin
      comp_pulldown_o <= (st == ST_HOFF);
      reference_input_node_pulldown_o <= (st == ST_HOFF);
      // dropping it whenever stopped makes every start a fresh ramp
      ss_enable_o <= sw;
    end
  end

  // ----------------------------------------------------------------------
  // power good deglitch
  // ----------------------------------------------------------------------
  assign pg_good = fl.fb_above_pg & fl.ref_ok;
  assign pg_bad = fl.fb_below_pg | ~fl.ref_ok;

  always_ff @(posedge mclk_i) begin
    if (rst_i || !run || !pg_good) begin
      good_cnt <= '0;
    end else if (good_cnt != PGCNT_W'(PG_CYC - 1)) begin
      good_cnt <= good_cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i || !run || !pg_bad) begin
      bad_cnt <= '0;
    end else if (bad_cnt != PGCNT_W'(PG_CYC - 1)) begin
      bad_cnt <= bad_cnt + 1'b1;
    end
  end

  // the pin is open drain: only ever pulled low, never driven high
  always_ff @(posedge mclk_i) begin
    power_good_flag_o <= 1'b0;
    if (rst_i || !run) begin
      power_good_flag_oe_o <= 1'b1;
    end else if (pg_good && good_cnt == PGCNT_W'(PG_CYC - 1)) begin
      power_good_flag_oe_o <= 1'b0;
    end else if (pg_bad && bad_cnt == PGCNT_W'(PG_CYC - 1)) begin
      power_good_flag_oe_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // output select straps
  // ----------------------------------------------------------------------
  // an illegal level code reads as open
  function automatic logic [1:0] lvl(input logic [1:0] v);
    lvl = (v == LVL_GND || v == LVL_VDD) ? v : LVL_OPEN;
  endfunction

  always_comb begin
    unique case ({lvl(fl.output_select_a), lvl(fl.output_select_b)})
      {LVL_GND, LVL_GND}: ratio_dec = 4'h0;
      {LVL_VDD, LVL_VDD}: ratio_dec = 4'h1;
      {LVL_GND, LVL_OPEN}: ratio_dec = 4'h2;
      {LVL_GND, LVL_VDD}: ratio_dec = 4'h3;
      {LVL_OPEN, LVL_GND}: ratio_dec = 4'h4;
      {LVL_OPEN, LVL_OPEN}: ratio_dec = 4'h5;
      {LVL_OPEN, LVL_VDD}: ratio_dec = 4'h6;
      {LVL_VDD, LVL_GND}: ratio_dec = 4'h7;
      default: ratio_dec = 4'h8;
    endcase
  end

  // strap moves while enabled are ignored until the next start
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sel_ratio_o <= 4'h0;
    end else if (run && st == ST_OFF) begin
      sel_ratio_o <= ratio_dec;
    end
  end

  // ----------------------------------------------------------------------
  // apb slave, one wait state
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && penable_i && !pready_o) begin
      pready_o <= 1'b1;
      pslverr_o <= (paddr_i != OFS_CTRL) && (paddr_i != OFS_STATUS);
      prdata_o <= 32'h0000_0000;
      if (!pwrite_i && paddr_i == OFS_CTRL) begin
        prdata_o[7:0] <= period;
      end else if (!pwrite_i && paddr_i == OFS_STATUS) begin
        prdata_o[RATIO_POS +: 4] <= sel_ratio_o;
        prdata_o[ST_POS +: 4] <= st;
        prdata_o[PG_POS] <= ~power_good_flag_oe_o;
        prdata_o[ILIM_POS] <= ilim_hold;
      end
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      period <= PERIOD_RST;
    end else if (psel_i && penable_i && pready_o && pwrite_i &&
                 paddr_i == OFS_CTRL) begin
      period <= (pwdata_i[7:0] < PERIOD_MIN) ? PERIOD_MIN : pwdata_i[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  no_overlap_a: assert property (!(hs_on_o && ls_on_o))
    else $error("both drives on together");
  ramp_stop_a: assert property (fl.ramp_trip |=> !hs_on_o)
    else $error("high side kept on after ramp trip");
  peak_hold_a: assert property ((ilim_hold && fl.ls_oc) ##1 sw
    |=> !hs_on_o) else $error("high side on during low side limit");
  hiccup_off_a: assert property ((st == ST_HOFF) |=>
    (!hs_on_o && !ls_on_o && comp_pulldown_o && reference_input_node_pulldown_o))
    else $error("hiccup did not hold switches off");
  hiccup_len_a: assert property ((st == ST_HOFF &&
    hcnt == HCNT_W'(HOFF_CYC - 1) && run) |=> (st == ST_HTRY))
    else $error("hiccup off time wrong");
  retry_fail_a: assert property ((st == ST_HTRY && fault_seen && run &&
    hcnt == HCNT_W'(HTRY_CYC - 1)) |=> (st == ST_HOFF))
    else $error("failed retry did not return to hiccup");
  pg_forced_a: assert property (!run |=> power_good_flag_oe_o)
    else $error("power good released while stopped");
  pg_release_a: assert property ($fell(power_good_flag_oe_o) |->
    $past(good_cnt) == PGCNT_W'(PG_CYC - 1))
    else $error("power good released before deglitch");
  pg_pull_a: assert property (($rose(power_good_flag_oe_o) &&
    $past(run)) |-> $past(bad_cnt) == PGCNT_W'(PG_CYC - 1))
    else $error("power good pulled before deglitch");
  sel_hold_a: assert property ((st != ST_OFF) |=> $stable(sel_ratio_o))
    else $error("output select changed while enabled");
  disable_off_a: assert property (!run |=> ##1 (!hs_on_o && !ls_on_o))
    else $error("switching while disabled");

endmodule

/* sim/bsc_far_side.sv */
// far-side model: ramp comparator and switch current sensing
module bsc_far_side (
  input wire logic mclk_i,
  input wire logic hs_on_i,
  input wire logic ls_on_i,
  input wire logic short_i,
  input wire logic [7:0] duty_i,
  output logic ramp_trip_o,
  output logic hs_oc_o,
  output logic ls_oc_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ramp = 8'h00;
  logic [3:0] sink = 4'h0;
  logic hs_q = 1'b0;
  // ---------------------------------------------------------------
  // sense outputs
  // ---------------------------------------------------------------
  // a sense only sees current while its own switch conducts
  assign ramp_trip_o = hs_on_i && (ramp >= duty_i);
  assign hs_oc_o = hs_on_i && short_i;
  assign ls_oc_o = ls_on_i && (sink != 4'h0);
  // ---------------------------------------------------------------
  // ramp and inductor decay
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    hs_q <= hs_on_i;
    ramp <= hs_on_i ? ramp + 8'h01 : 8'h00;
    // after a peak trip the inductor needs a few clocks to decay
    if (hs_q && !hs_on_i && short_i) begin
      sink <= 4'h8;
    end else if (sink != 4'h0) begin
      sink <= sink - 4'h1;
    end
  end
endmodule

/* sim/test_bsc_ctrl.sv */
// self-checking bench for the buck switch controller
module test_bsc_ctrl import bsc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  // ---------------------------------------------------------------
  // bench state
  // ---------------------------------------------------------------
  localparam logic [1:0] SA [9] = '{2'h0, 2'h2, 2'h0, 2'h0, 2'h1, 2'h1,
    2'h1, 2'h2, 2'h2};
  localparam logic [1:0] SB [9] = '{2'h0, 2'h2, 2'h1, 2'h2, 2'h0, 2'h1,
    2'h2, 2'h0, 2'h1};
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic fault = 1'b0;
  logic [7:0] duty = 8'h06;
  bsc_flags_s fl = '0;
  bsc_flags_s fin;
  logic rt, ho, lo, hs, ls, cpd, rpd, ss, pgo, pgoe, pgpin, rdy, serr;
  logic [31:0] rdata;
  logic [3:0] ratio;
  logic [31:0] rd;
  logic er;
  logic hs_d;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n, rise, hs_cyc, ls_cyc;

  always #20 mclk_i = ~mclk_i;
  // open-drain pin with a board pull-up
  assign pgpin = pgoe ? 1'b0 : 1'b1;
  always_comb begin
    fin = fl;
    fin.ramp_trip = rt;
    fin.hs_oc = ho;
    fin.ls_oc = lo;
  end

  bsc_ctrl dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(rdata), .pready_o(rdy),
    .pslverr_o(serr), .flags_i(fin), .hs_on_o(hs), .ls_on_o(ls),
    .comp_pulldown_o(cpd), .reference_input_node_pulldown_o(rpd), .ss_enable_o(ss),
    .sel_ratio_o(ratio), .power_good_flag_i(pgpin),
    .power_good_flag_o(pgo), .power_good_flag_oe_o(pgoe));
  bsc_far_side far (.mclk_i(mclk_i), .hs_on_i(hs), .ls_on_i(ls),
    .short_i(fault), .duty_i(duty), .ramp_trip_o(rt), .hs_oc_o(ho),
    .ls_oc_o(lo));
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
      input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk_i);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    int w;
    w = 0;
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do begin
      @(posedge mclk_i);
      w++;
    end while (rdy !== 1'b1 && w < 20);
    // a slave that never answers counts against the run
    if (rdy !== 1'b1) begin
      err_total++;
    end
    rd = rdata;
    er = serr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_len(input logic lvl);
    n = 0;
    while (cpd === lvl && n < 2000) begin
      tick(1);
      n++;
    end
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // monitor and timeout
  // ---------------------------------------------------------------
  always @(posedge mclk_i) begin
    cyc++;
    if (hs === 1'b1 && ls === 1'b1) begin
      check("overlap", 32'h1, 32'h0);
    end
    if (cyc == 10000) begin
      err_total++;
      report_and_stop();
    end
  end
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    tick(2);
    rst_i <= 1'b0;
    tick(6);
    check("rst_drv", {hs, ls, cpd, rpd, ss, pgoe, pgo}, 7'h02);
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    check("ctrl_rst", rd, 32'h0000_0019);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    check("st_rst", rd, 32'h0000_0100);
    apb(1'b1, OFS_CTRL, 32'h0000_0014);
    apb(1'b1, 8'h08, 32'h0000_00ff);
    check("bad_wr", er, 1'b1);
    apb(1'b0, 8'h08, 32'h0000_0000);
    check("bad_err", er, 1'b1);
    check("bad_rd", rd, 32'h0000_0000);
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    check("ctrl_wr", rd, 32'h0000_0014);
    // each strap pair, then a stray change while running
    for (int i = 0; i < 9; i++) begin
      fl.enable <= 1'b0;
      tick(8);
      fl.output_select_a <= SA[i];
      fl.output_select_b <= SB[i];
      tick(8);
      fl.enable <= 1'b1;
      tick(12);
      fl.output_select_a <= SA[(i + 1) % 9];
      tick(8);
      check("ratio", ratio, i[3:0]);
    end
    rise = 0;
    hs_cyc = 0;
    ls_cyc = 0;
    hs_d = 1'b0;
    for (int i = 0; i < 200; i++) begin
      tick(1);
      rise += (hs === 1'b1 && hs_d !== 1'b1);
      hs_cyc += (hs === 1'b1);
      ls_cyc += (ls === 1'b1);
      hs_d = hs;
    end
    check("hs_pulses", rise >= 8, 1'b1);
    check("hs_width", hs_cyc < 16 * rise, 1'b1);
    check("ls_fill", hs_cyc + ls_cyc >= 160, 1'b1);
    // no ramp trip now, so only the peak sense can end the pulse
    duty <= 8'h1f;
    tick(25);
    while (hs !== 1'b1) tick(1);
    fault <= 1'b1;
    n = 0;
    while (hs === 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    check("oc_cut", n < 8, 1'b1);
    tick(1);
    check("oc_ls", ls, 1'b1);
    fl.fb_low70 <= 1'b1;
    n = 0;
    while (cpd !== 1'b1 && n < 400) begin
      tick(1);
      n++;
    end
    check("blank_lo", n >= BLANK_CYC, 1'b1);
    check("blank_hi", n <= BLANK_CYC + 20, 1'b1);
    check("hic_off", {hs, ls, rpd}, 3'b001);
    run_len(1'b1);
    check("hoff", n, HOFF_CYC);
    run_len(1'b0);
    check("htry", n, HTRY_CYC);
    fault <= 1'b0;
    fl.fb_low70 <= 1'b0;
    tick(HOFF_CYC + HTRY_CYC + 20);
    check("recover", {cpd, ss}, 2'b01);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    check("st_run", rd[11:8], 4'h2);
    fl.ref_ok <= 1'b1;
    fl.fb_above_pg <= 1'b1;
    tick(40);
    check("pg_wait", pgoe, 1'b1);
    tick(30);
    check("pg_up", pgoe, 1'b0);
    fl.fb_above_pg <= 1'b0;
    fl.fb_below_pg <= 1'b1;
    tick(40);
    check("pg_hold", pgoe, 1'b0);
    tick(30);
    check("pg_down", pgoe, 1'b1);
    fl.fb_below_pg <= 1'b0;
    fl.fb_above_pg <= 1'b1;
    tick(70);
    check("pg_again", {pgoe, pgo}, 2'b00);
    fl.over_temp <= 1'b1;
    tick(2);
    check("ot_sync", ss, 1'b1);
    tick(8);
    check("ot_off", {ss, hs, ls, pgoe}, 4'b0001);
    fl.over_temp <= 1'b0;
    tick(12);
    check("ot_back", {ss, pgoe}, 2'b11);
    fl.supply_low <= 1'b1;
    tick(10);
    check("uv_off", {ss, hs, ls, pgoe}, 4'b0001);
    fl.supply_low <= 1'b0;
    tick(12);
    check("uv_back", ss, 1'b1);
    fl.enable <= 1'b0;
    tick(10);
    check("shut", {ss, hs, ls, pgoe, cpd, rpd}, 6'b000100);
    report_and_stop();
  end
endmodule
